// ==== bhp_pkg.sv ====
// Shared constants for the byte-wide host memory port and its host controller
package bhp_pkg;
  // RAM word address width and depth
  localparam int unsigned RAM_AW = 10;
  localparam int unsigned RAM_DEPTH = 1 << RAM_AW;
  // Register select codes on the two select pins
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_ADDR = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;
  // CPU data-space address of the control/status register
  localparam logic [15:0] CTRL_CPU_ADDR = 16'h002c;
  // Control/status bit positions
  localparam int unsigned BIT_ORDER = 0;
  localparam int unsigned BIT_CPU_IRQ = 1;
  localparam int unsigned BIT_HOST_IRQ = 2;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Pointer advance per completed word
  localparam logic [15:0] PTR_STEP = 16'h0001;
  // Pull-up level of an undriven data bus
  localparam logic [7:0] BUS_IDLE = 8'hff;
  // Host controller register offsets
  localparam logic [7:0] HR_WDATA = 8'h00;
  localparam logic [7:0] HR_CMD = 8'h04;
  localparam logic [7:0] HR_STATUS = 8'h08;
  localparam logic [7:0] HR_RDATA = 8'h0c;
  localparam logic [7:0] HR_CFG = 8'h10;
  // Host controller field positions
  localparam int unsigned CMD_WRITE = 0;
  localparam int unsigned CMD_SEL_LO = 1;
  localparam int unsigned CMD_SEL_HI = 2;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_IRQ = 1;
  localparam int unsigned CFG_ORDER = 0;
endpackage : bhp_pkg

// ==== bhp_if.sv ====
// Pin bundle between the host controller and the host memory port
`timescale 1ns/1ns
`default_nettype none
interface bhp_if;
  logic addr_strobe_n; // Address strobe, active low
  logic byte_position_in; // Low first byte, high second byte
  logic reg_select_0; // Register select bit 0
  logic reg_select_1; // Register select bit 1
  logic read_write_dir; // High read, low write
  logic port_chip_select_n; // Chip select, active low
  logic data_strobe_a_n; // Data strobe A, active low
  logic data_strobe_b_n; // Data strobe B, active low
  logic [7:0] host_data_out; // Host drive value
  logic host_data_oe; // Host drives the data bus
  logic [7:0] dev_data_out; // Device drive value
  logic dev_data_oe; // Device drives the data bus
  logic [7:0] byte_data_bus; // Resolved bus level
  logic interrupt_to_host; // Interrupt to host, active high
  logic port_ready_out; // Access may complete, active high
  // Resolved wire level, pulled up when nobody drives
  assign byte_data_bus = dev_data_oe ? dev_data_out :
                         (host_data_oe ? host_data_out : bhp_pkg::BUS_IDLE);
  modport device (
    input addr_strobe_n, byte_position_in, reg_select_0, reg_select_1, read_write_dir,
    input port_chip_select_n, data_strobe_a_n, data_strobe_b_n, byte_data_bus,
    output dev_data_out, dev_data_oe, interrupt_to_host, port_ready_out
  );
  modport host (
    output addr_strobe_n, byte_position_in, reg_select_0, reg_select_1, read_write_dir,
    output port_chip_select_n, data_strobe_a_n, data_strobe_b_n,
    output host_data_out, host_data_oe,
    input byte_data_bus, interrupt_to_host, port_ready_out
  );
endinterface : bhp_if
`default_nettype wire

// ==== bhp_device.sv ====
// Byte-wide host memory port: device end with on-chip RAM and CPU port
// Function
// R01: Pack byte pairs into 16-bit RAM words
// R02: Host moves every word as two bytes
// R03: Order bit picks half for first byte
// R04: Select pins choose control, pointer, data
// R05: Auto-increment data access advances the pointer
// R06: Data access performs RAM access by itself
// R07: Pointer addresses whole RAM, holds access address
// R08: Pointer and data reachable only by host
// R09: Control register also at CPU address 002Ch
// R10: Host accesses synchronous to the system clock
// R11: Same-location clash: host wins, CPU stalls
// R12: No host response while in reset
// R13: Host control write raises CPU interrupt
// R14: CPU control write raises host interrupt
// R15: Host control write clears host interrupt
// R16: Ready held low until access can finish
// R17: Data register reads/writes RAM at pointer
// R18: Byte-position low first, high second
// R19: Latch controls on address or data strobe
// R20: Data pins released when no access
// R21: Pointer advances one word per word
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module bhp_device (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  bhp_if.device pins,
  input wire logic [15:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [15:0] cpu_wdata_i,
  output logic [15:0] cpu_rdata_o,
  output logic cpu_stall_o,
  output logic cpu_irq_o
);
  localparam int unsigned AW = bhp_pkg::RAM_AW;

  // Host access sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_RAM, ST_LOAD, ST_HOLD} bhp_dev_state_t;

  bhp_dev_state_t state_r; // Sequencer state
  logic [15:0] ram_r [0:bhp_pkg::RAM_DEPTH-1]; // Shared on-chip RAM
  logic [15:0] ctrl_r; // Control/status register
  logic [15:0] ctrl_nxt; // Next control/status value
  logic [15:0] ptr_r; // RAM address pointer, host only
  logic [15:0] rd_word_r; // Word being returned to the host
  logic [7:0] first_byte_r; // First byte of a host write pair
  logic [7:0] out_byte_r; // Byte driven on the data pins
  logic oe_r; // Data pin drive enable
  logic rdy_r; // Ready to the host
  logic strobe_prev_r; // Strobe level one cycle back
  logic has_prev_r; // Address strobe one cycle back
  logic has_used_r; // Controls caught by the address strobe
  logic lat_bil_r; // Byte position caught by address strobe
  logic [1:0] lat_sel_r; // Select caught by address strobe
  logic lat_rd_r; // Direction caught by address strobe
  logic acc_bil_r; // Byte position of current access
  logic [1:0] acc_sel_r; // Select of current access
  logic acc_rd_r; // Direction of current access
  logic pend_v_r; // Stalled CPU access waits
  logic [15:0] pend_addr_r; // Stalled CPU address
  logic pend_wr_r; // Stalled CPU write
  logic pend_rd_r; // Stalled CPU read
  logic [15:0] pend_wdata_r; // Stalled CPU write data

  // Strobe decode: chip select with either data strobe
  wire strobe_w = ~pins.port_chip_select_n & ~(pins.data_strobe_a_n & pins.data_strobe_b_n);
  wire strobe_start_w = strobe_w & ~strobe_prev_r;
  wire has_fall_w = has_prev_r & ~pins.addr_strobe_n;
  wire [1:0] pin_sel_w = {pins.reg_select_1, pins.reg_select_0};
  // Controls taken from address strobe latch, else from the pins now
  wire take_bil_w = has_used_r ? lat_bil_r : pins.byte_position_in; // R19
  wire [1:0] take_sel_w = has_used_r ? lat_sel_r : pin_sel_w; // R19
  wire take_rd_w = has_used_r ? lat_rd_r : pins.read_write_dir; // R19

  // Access decode for the RAM step
  wire in_ram_w = (state_r == ST_RAM);
  wire is_data_w = (acc_sel_r == bhp_pkg::SEL_DATA) | (acc_sel_r == bhp_pkg::SEL_DATA_INC); // R04
  wire want_hi_w = acc_bil_r ^ ctrl_r[bhp_pkg::BIT_ORDER]; // R03
  wire [7:0] cur_byte_w = pins.byte_data_bus;
  wire [15:0] wr_word_w = ctrl_r[bhp_pkg::BIT_ORDER] ? {first_byte_r, cur_byte_w}
                                                     : {cur_byte_w, first_byte_r}; // R01 R03
  wire host_ram_wr_w = in_ram_w & ~acc_rd_r & is_data_w & acc_bil_r; // R06 R17
  wire host_ram_rd_w = in_ram_w & acc_rd_r & is_data_w & ~acc_bil_r; // R06 R17
  wire host_ram_w = host_ram_wr_w | host_ram_rd_w;
  wire [AW-1:0] host_idx_w = ptr_r[AW-1:0]; // R07
  wire host_ctrl_wr_w = in_ram_w & ~acc_rd_r & (acc_sel_r == bhp_pkg::SEL_CTRL) & acc_bil_r;
  wire host_ptr_wr_w = in_ram_w & ~acc_rd_r & (acc_sel_r == bhp_pkg::SEL_ADDR) & acc_bil_r;
  wire ptr_inc_w = in_ram_w & (acc_sel_r == bhp_pkg::SEL_DATA_INC) & acc_bil_r; // R05 R21
  wire load_word_w = in_ram_w & acc_rd_r & ~acc_bil_r;

  // CPU side: a stalled access replays ahead of new ones
  wire [15:0] eff_addr_w = pend_v_r ? pend_addr_r : cpu_addr_i;
  wire eff_wr_w = pend_v_r ? pend_wr_r : cpu_wr_i;
  wire eff_rd_w = pend_v_r ? pend_rd_r : cpu_rd_i;
  wire [15:0] eff_wdata_w = pend_v_r ? pend_wdata_r : cpu_wdata_i;
  wire cpu_ctrl_hit_w = (eff_addr_w == bhp_pkg::CTRL_CPU_ADDR); // R09
  wire [AW-1:0] cpu_idx_w = eff_addr_w[AW-1:0];
  wire cpu_ram_w = (eff_wr_w | eff_rd_w) & ~cpu_ctrl_hit_w;
  wire conflict_w = cpu_ram_w & host_ram_w & (cpu_idx_w == host_idx_w); // R11
  wire cpu_go_w = ~conflict_w;
  wire cpu_ctrl_wr_w = cpu_go_w & eff_wr_w & cpu_ctrl_hit_w; // R09

  // Straight-from-flop outputs
  assign pins.dev_data_out = out_byte_r;
  assign pins.dev_data_oe = oe_r;
  assign pins.port_ready_out = rdy_r;
  assign pins.interrupt_to_host = ctrl_r[bhp_pkg::BIT_HOST_IRQ]; // R14
  assign cpu_irq_o = ctrl_r[bhp_pkg::BIT_CPU_IRQ]; // R13
  assign cpu_stall_o = pend_v_r; // R11

  // Control register next value; sets are applied last so they win
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (cpu_ctrl_wr_w) begin
      ctrl_nxt[bhp_pkg::BIT_ORDER] = eff_wdata_w[bhp_pkg::BIT_ORDER];
      if (eff_wdata_w[bhp_pkg::BIT_CPU_IRQ]) begin
        ctrl_nxt[bhp_pkg::BIT_CPU_IRQ] = 1'b0;
      end
    end
    if (host_ctrl_wr_w) begin
      ctrl_nxt[bhp_pkg::BIT_ORDER] = wr_word_w[bhp_pkg::BIT_ORDER]; // R03
      if (wr_word_w[bhp_pkg::BIT_HOST_IRQ]) begin
        ctrl_nxt[bhp_pkg::BIT_HOST_IRQ] = 1'b0; // R15
      end
    end
    if (cpu_ctrl_wr_w && eff_wdata_w[bhp_pkg::BIT_HOST_IRQ]) begin
      ctrl_nxt[bhp_pkg::BIT_HOST_IRQ] = 1'b1; // R14
    end
    if (host_ctrl_wr_w && wr_word_w[bhp_pkg::BIT_CPU_IRQ]) begin
      ctrl_nxt[bhp_pkg::BIT_CPU_IRQ] = 1'b1; // R13
    end
  end

  // Strobe edge trackers and address-strobe control latch
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      strobe_prev_r <= 1'b0;
      has_prev_r <= 1'b1;
      has_used_r <= 1'b0;
      lat_bil_r <= 1'b0;
      lat_sel_r <= bhp_pkg::SEL_CTRL;
      lat_rd_r <= 1'b1;
    end else begin
      strobe_prev_r <= strobe_w; // R10
      has_prev_r <= pins.addr_strobe_n;
      if (has_fall_w) begin
        // Multiplexed host: controls valid at address strobe fall
        has_used_r <= 1'b1; // R19
        lat_bil_r <= pins.byte_position_in;
        lat_sel_r <= pin_sel_w;
        lat_rd_r <= pins.read_write_dir;
      end else if (state_r == ST_HOLD && !strobe_w) begin
        has_used_r <= 1'b0;
      end
    end
  end

  // Host access sequencer: RAM step, byte load, hold until strobe ends
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE; // R12
      acc_bil_r <= 1'b0;
      acc_sel_r <= bhp_pkg::SEL_CTRL;
      acc_rd_r <= 1'b1;
      rdy_r <= 1'b0;
      oe_r <= 1'b0;
      out_byte_r <= bhp_pkg::BUS_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // Latch controls at the later of select and data strobe
          if (strobe_start_w) begin
            acc_bil_r <= take_bil_w; // R19
            acc_sel_r <= take_sel_w; // R04
            acc_rd_r <= take_rd_w;
            state_r <= ST_RAM;
          end
        end
        ST_RAM: begin
          state_r <= ST_LOAD;
        end
        ST_LOAD: begin
          // Pick the byte half, then release the host
          out_byte_r <= want_hi_w ? rd_word_r[15:8] : rd_word_r[7:0]; // R03 R17
          oe_r <= acc_rd_r;
          rdy_r <= 1'b1; // R16
          state_r <= ST_HOLD;
        end
        ST_HOLD: begin
          if (!strobe_w) begin
            oe_r <= 1'b0; // R20
            rdy_r <= 1'b0; // R16
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Host-only pointer, staged bytes and returned word
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ptr_r <= '0;
      first_byte_r <= '0;
      rd_word_r <= '0;
      ctrl_r <= bhp_pkg::CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (in_ram_w && !acc_rd_r && !acc_bil_r) begin
        first_byte_r <= cur_byte_w; // R01
      end
      if (host_ptr_wr_w) begin
        ptr_r <= wr_word_w; // R07 R08
      end else if (ptr_inc_w) begin
        ptr_r <= ptr_r + bhp_pkg::PTR_STEP; // R05 R21
      end
      if (load_word_w) begin
        // Whole word fetched on the first byte, second byte reuses it
        case (acc_sel_r)
          bhp_pkg::SEL_CTRL: rd_word_r <= ctrl_r;
          bhp_pkg::SEL_ADDR: rd_word_r <= ptr_r;
          default: rd_word_r <= ram_r[host_idx_w]; // R17
        endcase
      end
    end
  end

  // Shared RAM: host write and CPU write in one cycle never collide
  always_ff @(posedge clk_sys_i) begin
    if (host_ram_wr_w) begin
      ram_r[host_idx_w] <= wr_word_w; // R06 R17
    end
    if (cpu_go_w && eff_wr_w && !cpu_ctrl_hit_w) begin
      ram_r[cpu_idx_w] <= eff_wdata_w;
    end
  end

  // CPU read data and stall replay
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      cpu_rdata_o <= '0;
      pend_v_r <= 1'b0;
      pend_addr_r <= '0;
      pend_wr_r <= 1'b0;
      pend_rd_r <= 1'b0;
      pend_wdata_r <= '0;
    end else begin
      pend_v_r <= conflict_w; // R11
      if (conflict_w) begin
        pend_addr_r <= eff_addr_w;
        pend_wr_r <= eff_wr_w;
        pend_rd_r <= eff_rd_w;
        pend_wdata_r <= eff_wdata_w;
      end
      if (cpu_go_w && eff_rd_w) begin
        // Pointer and data register have no CPU address
        cpu_rdata_o <= cpu_ctrl_hit_w ? ctrl_r : ram_r[cpu_idx_w]; // R08 R09
      end
    end
  end
endmodule : bhp_device
`default_nettype wire

// ==== bhp_host.sv ====
// Host controller driving the byte-wide host memory port pins
`timescale 1ns/1ns
`default_nettype none
module bhp_host (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  bhp_if.host pins,
  input wire logic [7:0] sw_addr_i,
  input wire logic [15:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [15:0] sw_rdata_o,
  output logic host_irq_o
);
  // Byte cycle states
  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_RELEASE} bhp_host_state_t;

  bhp_host_state_t state_r; // Byte cycle state
  logic [15:0] wdata_r; // Word to send
  logic [15:0] rdata_r; // Word received
  logic [1:0] sel_r; // Register select of the command
  logic write_r; // Command is a write
  logic second_r; // Second byte in progress
  logic order_r; // Host copy of the byte order bit
  logic cs_n_r; // Chip select drive
  logic ds_n_r; // Data strobe A drive
  logic bil_r; // Byte position drive
  logic [7:0] dout_r; // Data drive value
  logic doe_r; // Data drive enable

  wire busy_w = (state_r != H_IDLE);
  wire cmd_w = sw_wr_i & (sw_addr_i == bhp_pkg::HR_CMD) & ~busy_w;
  wire use_hi_w = second_r ^ order_r;
  wire next_hi_w = 1'b1 ^ order_r;

  // Pins straight from flops; address strobe unused, data strobe B idle
  assign pins.addr_strobe_n = 1'b1;
  assign pins.data_strobe_b_n = 1'b1;
  assign pins.port_chip_select_n = cs_n_r;
  assign pins.data_strobe_a_n = ds_n_r;
  assign pins.byte_position_in = bil_r;
  assign pins.reg_select_0 = sel_r[0];
  assign pins.reg_select_1 = sel_r[1];
  assign pins.read_write_dir = ~write_r;
  assign pins.host_data_out = dout_r;
  assign pins.host_data_oe = doe_r;

  // Byte cycle sequencer: two byte accesses per command
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_r <= H_IDLE;
      sel_r <= bhp_pkg::SEL_CTRL;
      write_r <= 1'b0;
      second_r <= 1'b0;
      cs_n_r <= 1'b1;
      ds_n_r <= 1'b1;
      bil_r <= 1'b0;
      dout_r <= '0;
      doe_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      case (state_r)
        H_IDLE: begin
          if (cmd_w) begin
            // First byte: position low, setup before strobe
            sel_r <= sw_wdata_i[bhp_pkg::CMD_SEL_HI:bhp_pkg::CMD_SEL_LO]; // R04
            write_r <= sw_wdata_i[bhp_pkg::CMD_WRITE];
            second_r <= 1'b0;
            bil_r <= 1'b0; // R18
            cs_n_r <= 1'b0;
            dout_r <= order_r ? wdata_r[15:8] : wdata_r[7:0];
            doe_r <= sw_wdata_i[bhp_pkg::CMD_WRITE];
            state_r <= H_SETUP;
          end
        end
        H_SETUP: begin
          ds_n_r <= 1'b0;
          state_r <= H_STROBE;
        end
        H_STROBE: begin
          // Wait states until the port shows ready
          if (pins.port_ready_out) begin
            if (!write_r) begin
              if (use_hi_w) begin
                rdata_r[15:8] <= pins.byte_data_bus;
              end else begin
                rdata_r[7:0] <= pins.byte_data_bus;
              end
            end
            ds_n_r <= 1'b1;
            cs_n_r <= 1'b1;
            doe_r <= 1'b0;
            state_r <= H_RELEASE;
          end
        end
        H_RELEASE: begin
          if (second_r) begin
            state_r <= H_IDLE;
          end else begin
            // Second byte of the pair follows at once
            second_r <= 1'b1; // R02
            bil_r <= 1'b1; // R18
            cs_n_r <= 1'b0;
            dout_r <= next_hi_w ? wdata_r[15:8] : wdata_r[7:0];
            doe_r <= write_r;
            state_r <= H_SETUP;
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
    end
  end

  // Software registers, read data one cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wdata_r <= '0;
      order_r <= 1'b0;
      sw_rdata_o <= '0;
      host_irq_o <= 1'b0;
    end else begin
      host_irq_o <= pins.interrupt_to_host;
      if (sw_wr_i && !busy_w && sw_addr_i == bhp_pkg::HR_WDATA) begin
        wdata_r <= sw_wdata_i;
      end
      if (sw_wr_i && sw_addr_i == bhp_pkg::HR_CFG) begin
        order_r <= sw_wdata_i[bhp_pkg::CFG_ORDER];
      end
      if (sw_rd_i) begin
        case (sw_addr_i)
          bhp_pkg::HR_WDATA: sw_rdata_o <= wdata_r;
          bhp_pkg::HR_RDATA: sw_rdata_o <= rdata_r;
          bhp_pkg::HR_CFG: sw_rdata_o <= {15'h0000, order_r};
          bhp_pkg::HR_STATUS: sw_rdata_o <= {14'h0000, host_irq_o, busy_w};
          default: sw_rdata_o <= '0;
        endcase
      end
    end
  end
endmodule : bhp_host
`default_nettype wire

// ==== bhp_sva.sv ====
// Concurrent checks on the pins between the host controller and the memory port
`timescale 1ns/1ns
`default_nettype none
module bhp_sva (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic byte_position_in,
  input wire logic reg_select_0,
  input wire logic reg_select_1,
  input wire logic read_write_dir,
  input wire logic port_chip_select_n,
  input wire logic data_strobe_a_n,
  input wire logic data_strobe_b_n,
  input wire logic dev_data_oe,
  input wire logic interrupt_to_host,
  input wire logic port_ready_out
);
  // Access strobe as the device sees it
  wire strobe_on = !port_chip_select_n && (!data_strobe_a_n || !data_strobe_b_n);
  wire [1:0] sel_now = {reg_select_1, reg_select_0}; // Current register select
  logic strobe_d_r; // Strobe one cycle ago
  logic last_bil_r; // Byte position of the last access
  logic [1:0] last_sel_r; // Select of the last access
  wire strobe_start = strobe_on && !strobe_d_r; // First cycle of an access
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Remember position and select of each access start
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      strobe_d_r <= 1'b0;
      last_bil_r <= 1'b1;
      last_sel_r <= 2'h0;
    end else begin
      strobe_d_r <= strobe_on;
      if (strobe_start) begin
        last_bil_r <= byte_position_in;
        last_sel_r <= sel_now;
      end
    end
  end
  ready_after_reset_a: assert property ($past(reset_i) |-> !port_ready_out && !dev_data_oe)
    else $error("port active right after reset");
  ready_latency_a: assert property (strobe_start |-> !port_ready_out [*3] ##1 port_ready_out)
    else $error("ready not three cycles after access start");
  ready_hold_a: assert property (port_ready_out && strobe_on |=> port_ready_out)
    else $error("ready dropped while strobe active");
  ready_drop_a: assert property (port_ready_out && !strobe_on |=> !port_ready_out)
    else $error("ready stayed after strobe ended");
  bus_release_a: assert property (dev_data_oe |-> $past(strobe_on))
    else $error("device drives bus with no access");
  read_drive_a: assert property (dev_data_oe |-> $past(read_write_dir))
    else $error("device drives bus on a write");
  byte_turn_a: assert property (strobe_start |-> byte_position_in != last_bil_r)
    else $error("byte position did not alternate");
  pair_select_a: assert property (strobe_start && byte_position_in |-> sel_now == last_sel_r)
    else $error("second byte used another select");
  host_hold_a: assert property (strobe_on && !port_ready_out |=> strobe_on && $stable(sel_now)
    && $stable(byte_position_in) && $stable(read_write_dir))
    else $error("host changed request before ready");
  host_release_a: assert property (port_ready_out && strobe_on |=> !strobe_on)
    else $error("host kept strobe after ready");
  // Main scenarios reached
  cover property (strobe_start && read_write_dir);
  cover property (strobe_start && !read_write_dir && sel_now == bhp_pkg::SEL_DATA_INC);
  cover property ($rose(interrupt_to_host));
endmodule : bhp_sva
`default_nettype wire

// ==== bhp_tb.sv ====
// Self-checking bench joining the host controller and the memory port
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys_i = 1'b0; // System clock
  logic reset_i = 1'b1; // Synchronous reset
  logic [7:0] sw_addr = 8'h00; // Software port request
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  logic host_irq;
  logic [15:0] cpu_addr = 16'h0000; // CPU port request
  logic [15:0] cpu_wdata = 16'h0000;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [15:0] cpu_rdata;
  logic cpu_stall;
  logic cpu_irq;
  logic [7:0] cap [2]; // Wire byte at completion, by position
  logic [15:0] val; // Last value read
  int err_count = 0;
  int samples_checked = 0;
  bhp_if bus_if ();
  bhp_device bhp_device_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pins(bus_if),
    .cpu_addr_i(cpu_addr), .cpu_wr_i(cpu_wr), .cpu_rd_i(cpu_rd), .cpu_wdata_i(cpu_wdata),
    .cpu_rdata_o(cpu_rdata), .cpu_stall_o(cpu_stall), .cpu_irq_o(cpu_irq));
  bhp_host bhp_host_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .pins(bus_if),
    .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd),
    .sw_rdata_o(sw_rdata), .host_irq_o(host_irq));
  bhp_sva bhp_sva_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .byte_position_in(bus_if.byte_position_in), .reg_select_0(bus_if.reg_select_0),
    .reg_select_1(bus_if.reg_select_1), .read_write_dir(bus_if.read_write_dir),
    .port_chip_select_n(bus_if.port_chip_select_n), .data_strobe_a_n(bus_if.data_strobe_a_n),
    .data_strobe_b_n(bus_if.data_strobe_b_n), .dev_data_oe(bus_if.dev_data_oe),
    .interrupt_to_host(bus_if.interrupt_to_host), .port_ready_out(bus_if.port_ready_out));
  // Clock generator
  always #20 clk_sys_i = ~clk_sys_i;
  // Record the byte on the wire when each access completes
  always @(posedge clk_sys_i) begin
    if (bus_if.port_ready_out && !bus_if.port_chip_select_n) begin
      cap[bus_if.byte_position_in] <= bus_if.byte_data_bus;
    end
  end
  // Compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Print the verdict and end the run
  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  // One-cycle software port write
  task automatic sw_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_sys_i);
    sw_wr <= 1'b0;
  endtask : sw_write
  // Software port read
  task automatic sw_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys_i);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_read
  // One word transfer over the pins
  task automatic host_op(input logic wr, input logic [1:0] sel, input logic [15:0] d,
                         output logic [15:0] q);
    logic [15:0] st;
    sw_write(bhp_pkg::HR_WDATA, d);
    sw_write(bhp_pkg::HR_CMD, {13'h0000, sel, wr});
    st = 16'h0001;
    for (int i = 0; i < 100 && st[bhp_pkg::ST_BUSY] !== 1'b0; i++) begin
      sw_read(bhp_pkg::HR_STATUS, st);
    end
    check("host idle", {15'h0000, st[bhp_pkg::ST_BUSY]}, 16'h0000);
    sw_read(bhp_pkg::HR_RDATA, q);
  endtask : host_op
  // One CPU access
  task automatic cpu_acc(input logic wr, input logic [15:0] a, input logic [15:0] d,
                         output logic [15:0] q);
    @(posedge clk_sys_i);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= wr;
    cpu_rd <= !wr;
    @(posedge clk_sys_i);
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
    #1 q = cpu_rdata;
  endtask : cpu_acc
  // Watchdog against a hang
  initial begin : watchdog
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    stop_test();
  end
  // Main sequence
  initial begin : main
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    cpu_acc(1'b0, bhp_pkg::CTRL_CPU_ADDR, 16'h0000, val);
    check("ctrl reset", val, bhp_pkg::CTRL_RESET);
    // Low byte first: pointer, two incrementing writes
    host_op(1'b1, bhp_pkg::SEL_ADDR, 16'h0010, val);
    host_op(1'b1, bhp_pkg::SEL_DATA_INC, 16'h1234, val);
    check("first byte low", {8'h00, cap[0]}, 16'h0034);
    host_op(1'b1, bhp_pkg::SEL_DATA_INC, 16'h5678, val);
    host_op(1'b0, bhp_pkg::SEL_ADDR, 16'h0000, val);
    check("pointer after writes", val, 16'h0012);
    cpu_acc(1'b0, 16'h0010, 16'h0000, val);
    check("ram word 0", val, 16'h1234);
    cpu_acc(1'b0, 16'h0011, 16'h0000, val);
    check("ram word 1", val, 16'h5678);
    // High byte first, plain data access at the top of RAM
    host_op(1'b1, bhp_pkg::SEL_CTRL, 16'h0101, val);
    sw_write(bhp_pkg::HR_CFG, 16'h0001);
    cpu_acc(1'b0, bhp_pkg::CTRL_CPU_ADDR, 16'h0000, val);
    check("ctrl order", val, 16'h0001);
    host_op(1'b1, bhp_pkg::SEL_ADDR, 16'h03ff, val);
    host_op(1'b1, bhp_pkg::SEL_DATA, 16'habcd, val);
    check("first byte high", {8'h00, cap[0]}, 16'h00ab);
    host_op(1'b0, bhp_pkg::SEL_DATA, 16'h0000, val);
    check("plain data read", val, 16'habcd);
    host_op(1'b0, bhp_pkg::SEL_ADDR, 16'h0000, val);
    check("pointer held", val, 16'h03ff);
    cpu_acc(1'b0, 16'h03ff, 16'h0000, val);
    check("ram top", val, 16'habcd);
    // CPU fills RAM, host reads it back with increment
    cpu_acc(1'b1, 16'h0100, 16'h55aa, val);
    cpu_acc(1'b1, 16'h0101, 16'h0f0f, val);
    host_op(1'b1, bhp_pkg::SEL_ADDR, 16'h0100, val);
    host_op(1'b0, bhp_pkg::SEL_DATA_INC, 16'h0000, val);
    check("inc read 0", val, 16'h55aa);
    check("read wire byte", {8'h00, cap[0]}, 16'h0055);
    host_op(1'b0, bhp_pkg::SEL_DATA_INC, 16'h0000, val);
    check("inc read 1", val, 16'h0f0f);
    host_op(1'b0, bhp_pkg::SEL_ADDR, 16'h0000, val);
    check("pointer after reads", val, 16'h0102);
    // Host and CPU hit one word at once
    fork
      host_op(1'b1, bhp_pkg::SEL_DATA, 16'h2468, val);
      begin
        repeat (11) @(posedge clk_sys_i);
        cpu_acc(1'b0, 16'h0102, 16'h0000, val);
        check("stall", {15'h0000, cpu_stall}, 16'h0001);
        @(posedge clk_sys_i);
        #1 check("stall read", cpu_rdata, 16'h2468);
      end
    join
    // Interrupts in both directions
    host_op(1'b1, bhp_pkg::SEL_CTRL, 16'h0303, val);
    check("cpu irq set", {15'h0000, cpu_irq}, 16'h0001);
    cpu_acc(1'b1, bhp_pkg::CTRL_CPU_ADDR, 16'h0005, val);
    repeat (2) @(posedge clk_sys_i);
    check("host irq pin", {15'h0000, bus_if.interrupt_to_host}, 16'h0001);
    sw_read(bhp_pkg::HR_STATUS, val);
    check("host irq status", {15'h0000, val[bhp_pkg::ST_IRQ]}, 16'h0001);
    host_op(1'b1, bhp_pkg::SEL_CTRL, 16'h0505, val);
    check("host irq cleared", {15'h0000, bus_if.interrupt_to_host}, 16'h0000);
    // Second reset in mid-run
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    cpu_acc(1'b0, bhp_pkg::CTRL_CPU_ADDR, 16'h0000, val);
    check("ctrl after reset", val, bhp_pkg::CTRL_RESET);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
